// file: src/fpm_pkg.sv
// Constants and types for the front panel setup menu
package fpm_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam longint SETUP_HOLD_NS = 64'd1_000_000_000;
  localparam int SETUP_HOLD_CYC = int'(SETUP_HOLD_NS / CLK_PERIOD_NS);
  localparam longint SAVE_STEP_NS = 64'd100_000_000;
  localparam int SAVE_STEP_CYC = int'(SAVE_STEP_NS / CLK_PERIOD_NS);
  localparam logic [2:0] SAVE_BAR_LEN = 3'd5;
  // Key indexes
  localparam int K_UP = 0;
  localparam int K_DN = 1;
  localparam int K_ENT = 2;
  localparam int K_RST = 3;
  localparam int K_SET = 4;
  localparam int K_LIM = 5;
  localparam int N_KEYS = 6;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SETTINGS = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_PW1 = 8'h0c;
  localparam logic [7:0] OFS_PW2 = 8'h10;
  localparam logic [7:0] OFS_PW3 = 8'h14;
  localparam logic [7:0] OFS_CAL = 8'h18;
  // Settings fields
  localparam int F_FP = 0;
  localparam int F_EXC = 1;
  localparam int F_FILT = 3;
  localparam int F_DEC = 7;
  localparam int F_FAST = 10;
  // Excitation codes, filter range and reset values
  localparam logic [1:0] EXC_1V5 = 2'h0;
  localparam logic [1:0] EXC_10V = 2'h3;
  localparam logic [3:0] FILT_MIN = 4'h1;
  localparam logic [3:0] FILT_MAX = 4'h9;
  localparam logic [3:0] FILT_RESET = 4'h5;
  localparam logic [16:0] COUNT_RESET = 17'h00001;
  localparam logic [16:0] PW1_RESET = 17'h00001;
  localparam logic [16:0] PW2_RESET = 17'h00002;
  localparam logic [16:0] PW3_RESET = 17'h00003;
  // Cut-off in tenths of a hertz, filter values 1..9
  localparam logic [9:0] CUTOFF_DHZ [9] = '{10'd1000, 10'd750, 10'd500,
    10'd250, 10'd100, 10'd75, 10'd50, 10'd25, 10'd10};
  typedef enum logic [3:0] {ST_RUN, ST_LEVEL, ST_ENTRY, ST_MENU, ST_FPSUB,
    ST_PWSEL, ST_EXCSUB, ST_FILTSUB, ST_SAVE} fpm_state_t;
  typedef enum logic [3:0] {IT_FP, IT_EDITP, IT_EXC, IT_GAIN, IT_DP, IT_CAL,
    IT_LIN, IT_EOFF, IT_TARE, IT_FILT, IT_COUNT, IT_LIMITS,
    IT_RUN} fpm_item_t;
  typedef enum logic [1:0] {P_LOGIN, P_PWEDIT, P_COUNT} fpm_purpose_t;
endpackage : fpm_pkg

// file: src/fpm_front_panel_menu.sv
// Front panel setup menu controller with APB register access
// What this block does
// RULE1 - Displayed input is quantised to multiples of the stored count value
// RULE2 - Quantisation only on the display; limits and serial get raw value
// RULE3 - On a first-level item, RESET, or ENTER on run, returns to run
// RULE4 - Leaving the menus blanks display and shows a growing save bar
// RULE5 - Setup key held one second enters access, showing level prompt
// RULE6 - Up/down cycle three access levels opening more menu items
// RULE7 - Limits key picks level, then five-digit password entry opens
// RULE8 - Menu items follow the fixed order, ending with run
// RULE9 - Limits item covers four limits, or two with fast option
// RULE10 - Excitation takes one of four bipolar voltages 1.5/3/5/10 V
// RULE11 - Excitation defaults to 1.5 V
// RULE12 - Excitation sub-menu: up/down step, ENTER stores, both go to gain
// RULE13 - Excitation outputs follow the voltage shown while browsing
// RULE14 - Changing excitation clears calibration data
// RULE15 - Filter sub-menu steps value, ENTER stores, then count item
// RULE16 - Count item opens five-digit entry, then limits item
// RULE17 - Filter values 1..9 select cut-off 100 Hz down to 1 Hz
// RULE18 - Front panel off ignores run-time keys except setup
// RULE19 - Keys ignored and display held until saving completes
`timescale 1ns/10ps
module fpm_front_panel_menu import fpm_pkg::*; #(
  parameter int SETUP_HOLD = SETUP_HOLD_CYC,
  parameter int SAVE_STEP  = SAVE_STEP_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [N_KEYS-1:0]  keyPin,
  input  wire logic signed [23:0] measValue,
  output fpm_state_t              menuState,
  output fpm_item_t               menuItem,
  output logic      [1:0]         accessLevel,
  output logic      [3:0]         subValue,
  output logic      [19:0]        entryDigits,
  output logic      [2:0]         entryPos,
  output logic                    dispBlank,
  output logic      [2:0]         saveBar,
  output logic                    measShown,
  output logic signed [23:0]      dispValue,
  output logic signed [23:0]      rawValue,
  output logic      [2:0]         dispDecimals,
  output logic      [1:0]         excitOut,
  output logic      [9:0]         filterCutoff,
  output logic      [2:0]         limitCount,
  output logic                    calClear,
  output logic      [N_KEYS-1:0]  runKeys
);
  logic [N_KEYS-1:0] keyMeta, keySync, keyLast, press;
  fpm_purpose_t      purpose;
  logic [1:0]        pwSel;
  logic [31:0]       holdCnt, saveCnt;
  logic              frontPanelOn, fastLimit, calValid;
  logic [1:0]        excitation;
  logic [3:0]        filter;
  logic [16:0]       countValue;
  logic [16:0]       pw [3];
  logic [16:0]       entered;
  logic [31:0]       rdMux;
  logic              rdOk, apbWr;

  function automatic logic [16:0] fpm_digits_value(input logic [19:0] d);
    logic [16:0] acc;
    acc = '0;
    for (int i = 4; i >= 0; i--) begin
      acc = 17'(acc * 17'd10 + 17'(d[4*i+:4]));
    end
    return acc;
  endfunction : fpm_digits_value

  function automatic fpm_item_t fpm_first_item(input logic [1:0] lvl);
    unique case (lvl)
      2'd3:    return IT_FP;
      2'd2:    return IT_DP;
      default: return IT_FILT;
    endcase
  endfunction : fpm_first_item

  function automatic logic signed [23:0] fpm_quantise(
      input logic signed [23:0] v, input logic [16:0] c);
    logic [23:0] mag;
    logic [23:0] q;
    if (c < 17'd2) return v;
    mag = v[23] ? 24'(-v) : 24'(v);
    q = 24'(((mag + 24'(c >> 1)) / 24'(c)) * 24'(c));
    return v[23] ? -$signed(q) : $signed(q);
  endfunction : fpm_quantise

  // Key pins: two-stage sync, then press edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      keyMeta <= '0;
      keySync <= '0;
      keyLast <= '0;
    end else begin
      keyMeta <= keyPin;
      keySync <= keyMeta;
      keyLast <= keySync;
    end
  end
  assign press = keySync & ~keyLast;
  assign entered = fpm_digits_value(entryDigits);
  assign apbWr = psel & penable & pready & pwrite;

  // APB read decode
  always_comb begin
    rdMux = '0;
    rdOk = 1'b1;
    unique case (paddr)
      OFS_STATUS: rdMux = {14'h0, calValid, saveBar, accessLevel, 4'h0,
                           4'(menuItem), 4'(menuState)};
      OFS_SETTINGS: rdMux = {21'h0, fastLimit, dispDecimals, filter,
                             excitation, frontPanelOn};
      OFS_COUNT: rdMux = {15'h0, countValue};
      OFS_PW1: rdMux = {15'h0, pw[0]};
      OFS_PW2: rdMux = {15'h0, pw[1]};
      OFS_PW3: rdMux = {15'h0, pw[2]};
      OFS_CAL: rdMux = {31'h0, calValid};
      default: rdOk = 1'b0;
    endcase
  end

  // APB slave: one wait state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0 : rdMux;
        pslverr <= ~rdOk;
      end
    end
  end

  // Menu sequencer and stored settings
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      menuState <= ST_RUN;
      menuItem <= IT_FP;
      accessLevel <= 2'd1;
      subValue <= '0;
      entryDigits <= '0;
      entryPos <= '0;
      purpose <= P_LOGIN;
      pwSel <= '0;
      holdCnt <= '0;
      saveCnt <= '0;
      saveBar <= '0;
      dispBlank <= 1'b0;
      calClear <= 1'b0;
      frontPanelOn <= 1'b1;
      fastLimit <= 1'b0;
      calValid <= 1'b0;
      excitation <= EXC_1V5; // [RULE11]
      filter <= FILT_RESET;
      dispDecimals <= '0;
      countValue <= COUNT_RESET;
      pw[0] <= PW1_RESET;
      pw[1] <= PW2_RESET;
      pw[2] <= PW3_RESET;
    end else begin
      calClear <= 1'b0;
      if (apbWr) begin
        unique case (paddr)
          OFS_SETTINGS: begin
            frontPanelOn <= pwdata[F_FP];
            fastLimit <= pwdata[F_FAST];
            dispDecimals <= pwdata[F_DEC+:3];
            if (pwdata[F_FILT+:4] >= FILT_MIN &&
                pwdata[F_FILT+:4] <= FILT_MAX) begin
              filter <= pwdata[F_FILT+:4];
            end
            if (pwdata[F_EXC+:2] != excitation) begin
              calValid <= 1'b0; // [RULE14]
              calClear <= 1'b1;
            end
            excitation <= pwdata[F_EXC+:2];
          end
          OFS_COUNT: countValue <= pwdata[16:0];
          OFS_PW1: pw[0] <= pwdata[16:0];
          OFS_PW2: pw[1] <= pwdata[16:0];
          OFS_PW3: pw[2] <= pwdata[16:0];
          OFS_CAL: calValid <= pwdata[0];
          default: ;
        endcase
      end
      unique case (menuState)
        ST_RUN: begin
          if (keySync[K_SET]) begin
            holdCnt <= holdCnt + 32'd1;
            if (holdCnt >= 32'(SETUP_HOLD - 1)) begin // [RULE5]
              holdCnt <= '0;
              accessLevel <= 2'd1;
              menuState <= ST_LEVEL;
            end
          end else begin
            holdCnt <= '0;
          end
        end
        ST_LEVEL: begin
          if (press[K_UP]) begin // [RULE6]
            accessLevel <= (accessLevel == 2'd3) ? 2'd1 : accessLevel + 2'd1;
          end else if (press[K_DN]) begin
            accessLevel <= (accessLevel == 2'd1) ? 2'd3 : accessLevel - 2'd1;
          end else if (press[K_LIM]) begin // [RULE7]
            purpose <= P_LOGIN;
            entryDigits <= '0;
            entryPos <= '0;
            menuState <= ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          if (press[K_UP]) begin
            entryDigits[4*entryPos+:4] <= (entryDigits[4*entryPos+:4] ==
              4'h9) ? 4'h0 : entryDigits[4*entryPos+:4] + 4'h1;
          end else if (press[K_DN]) begin
            entryDigits[4*entryPos+:4] <= (entryDigits[4*entryPos+:4] ==
              4'h0) ? 4'h9 : entryDigits[4*entryPos+:4] - 4'h1;
          end else if (press[K_ENT] &&
                       (press[K_RST] || entryPos == 3'd4)) begin
            unique case (purpose)
              P_LOGIN: begin
                if (entered == pw[accessLevel-2'd1]) begin
                  menuItem <= fpm_first_item(accessLevel); // [RULE6]
                  menuState <= ST_MENU;
                end else begin
                  menuState <= ST_RUN;
                end
              end
              P_PWEDIT: begin
                pw[pwSel] <= entered;
                pwSel <= (pwSel == 2'd2) ? 2'd0 : pwSel + 2'd1;
                menuState <= ST_PWSEL;
              end
              P_COUNT: begin
                countValue <= entered;
                menuItem <= IT_LIMITS; // [RULE16]
                menuState <= ST_MENU;
              end
            endcase
          end else if (press[K_ENT]) begin
            entryPos <= entryPos + 3'd1;
          end else if (press[K_RST]) begin
            menuState <= (purpose == P_LOGIN) ? ST_RUN :
                         (purpose == P_PWEDIT) ? ST_PWSEL : ST_MENU;
          end
        end
        ST_MENU: begin
          if (press[K_RST] || (press[K_ENT] && menuItem == IT_RUN)) begin
            saveCnt <= '0; // [RULE3]
            saveBar <= '0;
            dispBlank <= 1'b1; // [RULE4]
            menuState <= ST_SAVE;
          end else if (press[K_DN] && menuItem != IT_RUN) begin
            menuItem <= fpm_item_t'(4'(menuItem) + 4'h1); // [RULE8]
          end else if (press[K_UP] &&
                       menuItem != fpm_first_item(accessLevel)) begin
            menuItem <= fpm_item_t'(4'(menuItem) - 4'h1);
          end else if (press[K_ENT]) begin
            unique case (menuItem)
              IT_FP: begin
                subValue <= {3'h0, frontPanelOn};
                menuState <= ST_FPSUB;
              end
              IT_EDITP: begin
                pwSel <= '0;
                menuState <= ST_PWSEL;
              end
              IT_EXC: begin
                subValue <= {2'h0, excitation};
                menuState <= ST_EXCSUB;
              end
              IT_FILT: begin
                subValue <= filter;
                menuState <= ST_FILTSUB;
              end
              IT_COUNT: begin
                purpose <= P_COUNT; // [RULE16]
                entryDigits <= '0;
                entryPos <= '0;
                menuState <= ST_ENTRY;
              end
              default: ;
            endcase
          end
        end
        ST_FPSUB: begin
          if (press[K_UP] || press[K_DN]) begin
            subValue[0] <= ~subValue[0];
          end else if (press[K_ENT] || press[K_RST]) begin
            if (press[K_ENT]) frontPanelOn <= subValue[0];
            menuItem <= IT_EDITP;
            menuState <= ST_MENU;
          end
        end
        ST_PWSEL: begin
          if (press[K_UP]) begin
            pwSel <= (pwSel == 2'd2) ? 2'd0 : pwSel + 2'd1;
          end else if (press[K_DN]) begin
            pwSel <= (pwSel == 2'd0) ? 2'd2 : pwSel - 2'd1;
          end else if (press[K_ENT]) begin
            purpose <= P_PWEDIT;
            entryDigits <= '0;
            entryPos <= '0;
            menuState <= ST_ENTRY;
          end else if (press[K_RST]) begin
            menuItem <= IT_EXC;
            menuState <= ST_MENU;
          end
        end
        ST_EXCSUB: begin
          if (press[K_UP]) begin // [RULE10] [RULE12]
            subValue <= (subValue[1:0] == EXC_10V) ? {2'h0, EXC_1V5} :
                        subValue + 4'h1;
          end else if (press[K_DN]) begin
            subValue <= (subValue[1:0] == EXC_1V5) ? {2'h0, EXC_10V} :
                        subValue - 4'h1;
          end else if (press[K_ENT] || press[K_RST]) begin
            if (press[K_ENT]) begin
              excitation <= subValue[1:0];
              if (subValue[1:0] != excitation) begin
                calValid <= 1'b0; // [RULE14]
                calClear <= 1'b1;
              end
            end
            menuItem <= IT_GAIN; // [RULE12]
            menuState <= ST_MENU;
          end
        end
        ST_FILTSUB: begin
          if (press[K_UP]) begin // [RULE15]
            subValue <= (subValue == FILT_MAX) ? FILT_MIN : subValue + 4'h1;
          end else if (press[K_DN]) begin
            subValue <= (subValue == FILT_MIN) ? FILT_MAX : subValue - 4'h1;
          end else if (press[K_ENT] || press[K_RST]) begin
            if (press[K_ENT]) filter <= subValue;
            menuItem <= IT_COUNT;
            menuState <= ST_MENU;
          end
        end
        ST_SAVE: begin
          saveCnt <= saveCnt + 32'd1; // [RULE19]
          if (saveCnt >= 32'(SAVE_STEP - 1)) begin
            saveCnt <= '0;
            saveBar <= saveBar + 3'd1; // [RULE4]
            if (saveBar == SAVE_BAR_LEN - 3'd1) begin
              saveBar <= '0;
              dispBlank <= 1'b0;
              menuState <= ST_RUN;
            end
          end
        end
      endcase
    end
  end

  // Display, excitation and run-time key outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      measShown <= 1'b0;
      dispValue <= '0;
      rawValue <= '0;
      excitOut <= EXC_1V5;
      filterCutoff <= CUTOFF_DHZ[0];
      limitCount <= 3'd4;
      runKeys <= '0;
    end else begin
      measShown <= (menuState == ST_RUN); // [RULE19]
      dispValue <= fpm_quantise(measValue, countValue); // [RULE1]
      rawValue <= measValue; // [RULE2]
      excitOut <= (menuState == ST_EXCSUB) ? subValue[1:0] :
                  excitation; // [RULE13]
      filterCutoff <= CUTOFF_DHZ[filter - FILT_MIN]; // [RULE17]
      limitCount <= fastLimit ? 3'd2 : 3'd4; // [RULE9]
      runKeys <= (menuState == ST_RUN && frontPanelOn) ?
                 (press & ~(N_KEYS'(1) << K_SET)) : '0; // [RULE18]
    end
  end
endmodule : fpm_front_panel_menu

// file: dv/fpm_menu_assertions.sv
// Port checker for the front panel setup menu
`timescale 1ns/10ps
module fpm_menu_checker import fpm_pkg::*; #(
  parameter int SETUP_HOLD = SETUP_HOLD_CYC,
  parameter int SAVE_STEP  = SAVE_STEP_CYC
) (
  input wire logic               clk,
  input wire logic               rst_b,
  input fpm_state_t              menuState,
  input fpm_item_t               menuItem,
  input wire logic [1:0]         accessLevel,
  input wire logic [3:0]         subValue,
  input wire logic               dispBlank,
  input wire logic [2:0]         saveBar,
  input wire logic               measShown,
  input wire logic signed [23:0] measValue,
  input wire logic signed [23:0] rawValue,
  input wire logic [1:0]         excitOut,
  input wire logic [9:0]         filterCutoff,
  input wire logic [2:0]         limitCount,
  input wire logic               calClear,
  input wire logic [N_KEYS-1:0]  runKeys
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] prevBar;
  int         stepCnt;
  // Cycles the save bar has stood still
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prevBar <= 3'h0;
      stepCnt <= 0;
    end else begin
      prevBar <= saveBar;
      stepCnt <= (menuState == ST_SAVE && saveBar == prevBar) ?
                 stepCnt + 1 : 0;
    end
  end
  a_save_blank: assert property (
    menuState == ST_SAVE |-> dispBlank && !measShown)
    else $error("Display shown during save");
  a_bar_grows: assert property (
    menuState == ST_SAVE && $past(menuState) == ST_SAVE
    |-> saveBar <= 3'h4 && saveBar >= $past(saveBar))
    else $error("Save bar shrank or overran");
  a_bar_step: assert property (stepCnt <= SAVE_STEP + 1)
    else $error("Save bar stalled");
  a_excit_shown: assert property (
    menuState == ST_EXCSUB && $past(menuState) == ST_EXCSUB
    && $stable(subValue) |-> excitOut == subValue[1:0])
    else $error("Excitation output differs from shown value");
  a_menu_order: assert property (
    menuState == ST_MENU && $past(menuState) == ST_MENU
    && $changed(menuItem) |-> menuItem == $past(menuItem) + 4'h1
    || menuItem == $past(menuItem) - 4'h1)
    else $error("Menu item skipped");
  a_cutoff_table: assert property (filterCutoff inside {10'd1000,
    10'd750, 10'd500, 10'd250, 10'd100, 10'd75, 10'd50, 10'd25, 10'd10})
    else $error("Cut-off not in table");
  a_limit_count: assert property (limitCount inside {3'h4, 3'h2})
    else $error("Bad limit count");
  a_level_range: assert property (accessLevel inside {2'h1, 2'h2, 2'h3})
    else $error("Access level out of range");
  a_cal_pulse: assert property (calClear |=> !calClear)
    else $error("Calibration clear longer than one cycle");
  a_setup_gated: assert property (runKeys[K_SET] == 1'b0)
    else $error("Setup key passed as run key");
  a_raw_follow: assert property (
    $past(rst_b) |-> rawValue == $past(measValue))
    else $error("Raw value altered");
endmodule : fpm_menu_checker

bind fpm_front_panel_menu fpm_menu_checker #(
  .SETUP_HOLD(SETUP_HOLD), .SAVE_STEP(SAVE_STEP)) chk_u (
  .clk(clk), .rst_b(rst_b), .menuState(menuState), .menuItem(menuItem),
  .accessLevel(accessLevel), .subValue(subValue), .dispBlank(dispBlank),
  .saveBar(saveBar), .measShown(measShown), .measValue(measValue),
  .rawValue(rawValue), .excitOut(excitOut), .filterCutoff(filterCutoff),
  .limitCount(limitCount), .calClear(calClear), .runKeys(runKeys));

// file: dv/fpm_keypad_model.sv
// Operator keypad model: presses keys for a set time, then releases
`timescale 1ns/10ps
module fpm_keypad_model import fpm_pkg::*; (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              reqGo,
  input  wire logic [N_KEYS-1:0] reqKeys,
  input  wire logic [7:0]        reqHold,
  output logic      [N_KEYS-1:0] keyPin,
  output logic                   busy
);
  logic [7:0] holdCnt;
  logic [3:0] gapCnt;
  // Released contacts read zero; the gap lets the release be seen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      keyPin  <= '0;
      busy    <= 1'b0;
      holdCnt <= 8'h0;
      gapCnt  <= 4'h0;
    end else if (reqGo) begin
      keyPin  <= reqKeys;
      holdCnt <= reqHold;
      busy    <= 1'b1;
      gapCnt  <= 4'h8;
    end else if (holdCnt != 8'h0) begin
      holdCnt <= holdCnt - 8'h1;
    end else if (keyPin != '0) begin
      keyPin <= '0;
    end else if (gapCnt != 4'h0) begin
      gapCnt <= gapCnt - 4'h1;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule : fpm_keypad_model

// file: dv/tb.sv
// Testbench for the front panel setup menu
`timescale 1ns/10ps
module tb import fpm_pkg::*;;
  localparam int HOLD = 20;
  localparam int STEP = 8;
  localparam logic [5:0] KU = 6'h01, KD = 6'h02, KE = 6'h04, KR = 6'h08;
  localparam logic [5:0] KS = 6'h10, KL = 6'h20;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, reqGo, busy;
  logic dispBlank, measShown, calClear, er;
  logic [7:0] paddr, reqHold;
  logic [31:0] pwdata, prdata, rd;
  logic [N_KEYS-1:0] keyPin, reqKeys, runKeys;
  logic signed [23:0] measValue, dispValue, rawValue;
  fpm_state_t menuState;
  fpm_item_t menuItem;
  logic [1:0] accessLevel, excitOut;
  logic [3:0] subValue;
  logic [19:0] entryDigits;
  logic [2:0] entryPos, saveBar, dispDecimals, limitCount;
  logic [9:0] filterCutoff;
  int errors = 0, testsRun = 0, cycles = 0, upCnt = 0, i;

  fpm_front_panel_menu #(.SETUP_HOLD(HOLD), .SAVE_STEP(STEP)) dut_u (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keyPin(keyPin),
    .measValue(measValue), .menuState(menuState), .menuItem(menuItem),
    .accessLevel(accessLevel), .subValue(subValue),
    .entryDigits(entryDigits), .entryPos(entryPos), .dispBlank(dispBlank),
    .saveBar(saveBar), .measShown(measShown), .dispValue(dispValue),
    .rawValue(rawValue), .dispDecimals(dispDecimals), .excitOut(excitOut),
    .filterCutoff(filterCutoff), .limitCount(limitCount),
    .calClear(calClear), .runKeys(runKeys));
  fpm_keypad_model key_u (.clk(clk), .rst_b(rst_b), .reqGo(reqGo),
    .reqKeys(reqKeys), .reqHold(reqHold), .keyPin(keyPin), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (runKeys[K_UP] === 1'b1) upCnt <= upCnt + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  task conclude();
    if (errors == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rdChk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(er), 32'(e));
  endtask : rdChk
  task press(input logic [5:0] k, input logic [7:0] h);
    int n;
    n = 0;
    reqKeys <= k;
    reqHold <= h;
    reqGo <= 1'b1;
    @(posedge clk);
    reqGo <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'b1 && n < 300);
  endtask : press
  task waitRun();
    for (i = 0; i < 200 && menuState !== ST_RUN; i++) @(posedge clk);
    @(posedge clk);
  endtask : waitRun

  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, reqGo} = 4'h0;
    {paddr, reqHold, pwdata, reqKeys, measValue} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(32'(excitOut), 32'h0);
    rdChk(OFS_SETTINGS, 32'h29, 1'b0);
    rdChk(OFS_COUNT, 32'h1, 1'b0);
    rdChk(OFS_STATUS, 32'h1000, 1'b0);
    rdChk(8'h1c, 32'h0, 1'b1);
    apb(1'b1, OFS_CAL, 32'h1);
    rdChk(OFS_CAL, 32'h1, 1'b0);
    apb(1'b1, OFS_SETTINGS, 32'h28);
    press(KU, 8'h3);
    chk(32'(upCnt), 32'h0);
    apb(1'b1, OFS_SETTINGS, 32'h29);
    press(KU, 8'h3);
    chk(32'(upCnt), 32'h1);
    press(KS, 8'(HOLD - 6));
    chk(32'(menuState), 32'(ST_RUN));
    press(KS, 8'(HOLD + 6));
    chk(32'(menuState), 32'(ST_LEVEL));
    chk(32'(accessLevel), 32'h1);
    press(KU, 8'h3);
    press(KU, 8'h3);
    chk(32'(accessLevel), 32'h3);
    press(KU, 8'h3);
    chk(32'(accessLevel), 32'h1);
    press(KD, 8'h3);
    chk(32'(accessLevel), 32'h3);
    press(KL, 8'h3);
    chk(32'(menuState), 32'(ST_ENTRY));
    chk({9'h0, entryPos, entryDigits}, 32'h0);
    repeat (3) press(KU, 8'h3);
    press(KE | KR, 8'h3);
    chk(32'(menuItem), 32'(IT_FP));
    for (int k = 1; k <= 2; k++) begin
      press(KD, 8'h3);
      chk(32'(menuItem), 32'(k));
    end
    press(KE, 8'h3);
    chk(32'(menuState), 32'(ST_EXCSUB));
    for (int k = 1; k <= 3; k++) begin
      press(KU, 8'h3);
      chk(32'(subValue), 32'(k));
      chk(32'(excitOut), 32'(k));
    end
    press(KE, 8'h3);
    chk(32'(menuItem), 32'(IT_GAIN));
    rdChk(OFS_CAL, 32'h0, 1'b0);
    rdChk(OFS_SETTINGS, 32'h2f, 1'b0);
    press(KU, 8'h3);
    press(KE, 8'h3);
    press(KD, 8'h3);
    chk(32'(excitOut), 32'h2);
    press(KR, 8'h3);
    chk(32'(menuItem), 32'(IT_GAIN));
    chk(32'(excitOut), 32'h3);
    for (int k = IT_DP; k <= IT_FILT; k++) begin
      press(KD, 8'h3);
      chk(32'(menuItem), 32'(k));
    end
    press(KE, 8'h3);
    chk(32'(subValue), 32'h5);
    press(KU, 8'h3);
    press(KE, 8'h3);
    chk(32'(menuItem), 32'(IT_COUNT));
    chk(32'(filterCutoff), 32'd75);
    press(KE, 8'h3);
    chk(32'(menuState), 32'(ST_ENTRY));
    repeat (4) press(KU, 8'h3);
    press(KE | KR, 8'h3);
    chk(32'(menuItem), 32'(IT_LIMITS));
    chk(32'(limitCount), 32'h4);
    press(KD, 8'h3);
    press(KE, 8'h3);
    chk(32'(menuState), 32'(ST_SAVE));
    chk(32'(dispBlank), 32'h1);
    press(KR, 8'h1);
    chk(32'(menuState), 32'(ST_SAVE));
    waitRun();
    chk(32'(measShown), 32'h1);
    rdChk(OFS_COUNT, 32'h4, 1'b0);
    rdChk(OFS_SETTINGS, 32'h37, 1'b0);
    measValue <= 24'sd10;
    repeat (3) @(posedge clk);
    chk(32'(dispValue), 32'd12);
    chk(32'(rawValue), 32'd10);
    measValue <= -24'sd5;
    repeat (3) @(posedge clk);
    chk(32'(dispValue), 32'hfffffffc);
    chk(32'(rawValue), 32'hfffffffb);
    apb(1'b1, OFS_SETTINGS, 32'h5b7);
    chk(32'(dispDecimals), 32'h3);
    @(posedge clk);
    chk(32'(limitCount), 32'h2);
    press(KS, 8'(HOLD + 6));
    press(KL, 8'h3);
    press(KU, 8'h3);
    press(KE | KR, 8'h3);
    press(KU, 8'h3);
    chk(32'(menuItem), 32'(IT_FILT));
    press(KR, 8'h3);
    chk(32'(menuState), 32'(ST_SAVE));
    waitRun();
    press(KS, 8'(HOLD + 6));
    press(KL, 8'h3);
    press(KE | KR, 8'h3);
    chk(32'(menuState), 32'(ST_RUN));
    apb(1'b1, OFS_PW3, 32'h0);
    press(KS, 8'(HOLD + 6));
    press(KD, 8'h3);
    press(KL, 8'h3);
    press(KE | KR, 8'h3);
    press(KE, 8'h3);
    press(KU, 8'h3);
    press(KE, 8'h3);
    chk(32'(menuItem), 32'(IT_EDITP));
    press(KE, 8'h3);
    press(KR, 8'h3);
    chk(32'(menuItem), 32'(IT_EXC));
    press(KR, 8'h3);
    waitRun();
    press(KU, 8'h3);
    chk(32'(upCnt), 32'h1);
    conclude();
  end
endmodule : tb
